// [src/exec_pkg.sv]
// constants and types shared by the execution unit and its register file
package exec_pkg;
	localparam int DATA_W = 8;
	localparam int FADDR_W = 7;
	localparam int PC_W = 15;
	localparam int BRANCH_W = 11;
	localparam int LATCH_W = 7;
	localparam int LATCH_LO = 3;
	localparam int LATCH_HI = 6;
	localparam int WDT_W = 8;
	localparam int PRE_W = 8;
	localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;
	localparam logic [DATA_W-1:0] ONE_BYTE = 8'h01;
	localparam logic [PC_W-1:0] PC_ONE = 15'h0001;
	localparam logic [WDT_W-1:0] WDT_ZERO = 8'h00;
	localparam logic [PRE_W-1:0] PRE_ZERO = 8'h00;
	localparam logic [LATCH_W-1:0] LATCH_RESET = 7'h00;
	localparam logic [PC_W-1:0] PC_RESET = 15'h0000;
	// apb map
	localparam logic [11:0] ADDR_CMD = 12'h000;
	localparam logic [11:0] ADDR_WREG = 12'h004;
	localparam logic [11:0] ADDR_STATUS = 12'h008;
	localparam logic [11:0] ADDR_PC = 12'h00c;
	localparam logic [11:0] ADDR_LATCH = 12'h010;
	localparam logic [11:0] ADDR_WDT = 12'h014;
	localparam logic [11:0] ADDR_FILE = 12'h018;
	localparam logic [11:0] ADDR_FDATA = 12'h01c;
	// command word fields
	localparam int CMD_OP_LO = 16;
	localparam int CMD_OP_W = 3;
	localparam int CMD_DEST_BIT = 11;
	localparam int STAT_Z = 0;
	localparam int STAT_PD = 1;
	localparam int STAT_TO = 2;
	localparam int STAT_BUSY = 3;
	localparam int STAT_SKIP = 4;
	typedef enum logic [2:0] {
		OP_CLEAR_FILE,
		OP_CLEAR_ACC,
		OP_WDT_CLEAR,
		OP_INVERT,
		OP_DECREMENT,
		OP_DEC_SKIP,
		OP_BRANCH,
		OP_NONE
	} op_t;
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_SECOND
	} state_t;
endpackage

// [src/file_regs.sv]
// 128-entry file register storage with one write and two read ports
`timescale 1ns/1ps
module file_regs
	import exec_pkg::*;
#(
	parameter int DEPTH = 128
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic wr_en,
	input wire logic [FADDR_W-1:0] wr_addr,
	input wire logic [DATA_W-1:0] wr_data,
	input wire logic [FADDR_W-1:0] rd_addr_a,
	output logic [DATA_W-1:0] rd_data_a,
	input wire logic [FADDR_W-1:0] rd_addr_b,
	output logic [DATA_W-1:0] rd_data_b
);
	logic [DATA_W-1:0] mem [DEPTH];

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < DEPTH; i++) begin
				mem[i] <= ZERO_BYTE;
			end
		end else if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
	end

	assign rd_data_a = mem[rd_addr_a];
	assign rd_data_b = mem[rd_addr_b];
endmodule

// [src/exec_unit.sv]
// execution of clear, invert, decrement, skip and branch ops behind apb
//
// Functional notes
// - clear file op writes zero to any file address and sets zero flag
// - clear accumulator op loads zero into accumulator and sets zero flag
// - watchdog clear op resets the watchdog counter to zero
// - watchdog clear op also resets prescaler in same operation
// - watchdog clear op sets both active-low timeout and powerdown bits
// - invert op produces bitwise inversion of the file register
// - invert destination: 0 to accumulator, 1 back to file register
// - decrement op subtracts one; destination chosen like invert
// - decrement-skip op subtracts one and stores by destination bit
// - zero result discards next instruction, executes nop, two cycles
// - branch loads 11-bit immediate into program counter bits 10:0
// - branch loads counter bits 14:11 from high latch bits 6:3
// - branch takes two instruction cycles
//
// The implementer's own choices: the APB register port and the register addresses.
`timescale 1ns/1ps
module exec_unit
	import exec_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic [PC_W-1:0] program_counter,
	output logic [WDT_W-1:0] watchdog_counter,
	output logic [PRE_W-1:0] watchdog_prescaler,
	output logic timeout_status_n,
	output logic powerdown_status_n,
	output logic discard_fetch
);
	// ==========================================================
	// state
	logic [DATA_W-1:0] acc;
	logic zero_flag;
	logic [LATCH_W-1:0] program_counter_high_latch;
	logic [FADDR_W-1:0] view_addr;
	logic skip_seen;
	state_t state;

	// ==========================================================
	// apb decode
	wire logic access = psel && penable;
	wire logic wr_acc = access && pwrite;
	wire logic busy = (state != ST_IDLE);
	wire logic hit_cmd = (paddr == ADDR_CMD);
	wire logic hit_wreg = (paddr == ADDR_WREG);
	wire logic hit_status = (paddr == ADDR_STATUS);
	wire logic hit_pc = (paddr == ADDR_PC);
	wire logic hit_latch = (paddr == ADDR_LATCH);
	wire logic hit_wdt = (paddr == ADDR_WDT);
	wire logic hit_file = (paddr == ADDR_FILE);
	wire logic hit_fdata = (paddr == ADDR_FDATA);
	wire logic mapped = hit_cmd || hit_wreg || hit_status || hit_pc || hit_latch
		|| hit_wdt || hit_file || hit_fdata;
	// a command issued while the second cycle runs waits for it
	assign pready = !(access && pwrite && hit_cmd && busy);
	assign pslverr = access && !mapped;

	// ==========================================================
	// command fields
	wire logic issue = wr_acc && hit_cmd && !busy;
	wire op_t op = op_t'(pwdata[CMD_OP_LO +: CMD_OP_W]);
	wire logic dest_file = pwdata[CMD_DEST_BIT];
	wire logic [FADDR_W-1:0] f_addr = pwdata[FADDR_W-1:0];
	wire logic [BRANCH_W-1:0] target = pwdata[BRANCH_W-1:0];

	// ==========================================================
	// datapath
	logic [DATA_W-1:0] f_val;
	logic [DATA_W-1:0] view_data;
	wire logic [DATA_W-1:0] inverted = ~f_val;
	wire logic [DATA_W-1:0] decremented = f_val - ONE_BYTE;
	wire logic is_inv = issue && (op == OP_INVERT);
	wire logic is_dec = issue && (op == OP_DECREMENT);
	wire logic is_dsk = issue && (op == OP_DEC_SKIP);
	wire logic is_clear_file_register_op = issue && (op == OP_CLEAR_FILE);
	wire logic is_clear_accumulator_op = issue && (op == OP_CLEAR_ACC);
	wire logic is_wdt = issue && (op == OP_WDT_CLEAR);
	wire logic is_br = issue && (op == OP_BRANCH);
	wire logic [DATA_W-1:0] result = is_inv ? inverted : decremented;
	wire logic unary = is_inv || is_dec || is_dsk;
	wire logic skip_now = is_dsk && (decremented == ZERO_BYTE);
	// skip steps the counter past the discarded word, a branch keeps its target
	wire logic [PC_W-1:0] pc_step = skip_now ? PC_ONE + PC_ONE : PC_ONE;
	// host write to file data register also updates storage
	wire logic host_fwr = wr_acc && hit_fdata;
	wire logic fwr_en = is_clear_file_register_op || (unary && dest_file) || host_fwr;
	wire logic [FADDR_W-1:0] fwr_addr = host_fwr ? view_addr : f_addr;
	wire logic [DATA_W-1:0] fwr_data = host_fwr ? pwdata[DATA_W-1:0]
		: (is_clear_file_register_op ? ZERO_BYTE : result);
	wire logic [PC_W-1:0] branch_pc = {program_counter_high_latch[LATCH_HI:LATCH_LO],
		target};

	file_regs u_file_regs (
		.pclk(pclk),
		.presetn(presetn),
		.wr_en(fwr_en),
		.wr_addr(fwr_addr),
		.wr_data(fwr_data),
		.rd_addr_a(f_addr),
		.rd_data_a(f_val),
		.rd_addr_b(view_addr),
		.rd_data_b(view_data)
	);

	// ==========================================================
	// accumulator and zero flag
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			acc <= ZERO_BYTE;
		end else if (is_clear_accumulator_op) begin
			acc <= ZERO_BYTE;
		end else if (unary && !dest_file) begin
			acc <= result;
		end else if (wr_acc && hit_wreg) begin
			acc <= pwdata[DATA_W-1:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			zero_flag <= 1'b0;
		end else if (is_clear_file_register_op || is_clear_accumulator_op) begin
			zero_flag <= 1'b1;
		end else if (is_inv || is_dec) begin
			zero_flag <= (result == ZERO_BYTE);
		end
	end

	// ==========================================================
	// watchdog and status bits
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			watchdog_counter <= WDT_ZERO;
			watchdog_prescaler <= PRE_ZERO;
		end else if (is_wdt) begin
			watchdog_counter <= WDT_ZERO;
			watchdog_prescaler <= PRE_ZERO;
		end else if (wr_acc && hit_wdt) begin
			watchdog_counter <= pwdata[WDT_W-1:0];
			watchdog_prescaler <= pwdata[WDT_W +: PRE_W];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			timeout_status_n <= 1'b1;
			powerdown_status_n <= 1'b1;
		end else if (is_wdt) begin
			timeout_status_n <= 1'b1;
			powerdown_status_n <= 1'b1;
		end else if (wr_acc && hit_status) begin
			timeout_status_n <= pwdata[STAT_TO];
			powerdown_status_n <= pwdata[STAT_PD];
		end
	end

	// ==========================================================
	// program counter and two-cycle sequencing
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			program_counter <= PC_RESET;
		end else if (is_br) begin
			program_counter <= branch_pc;
		end else if (issue) begin
			program_counter <= program_counter + pc_step;
		end else if (wr_acc && hit_pc) begin
			program_counter <= pwdata[PC_W-1:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= ST_IDLE;
		end else begin
			case (state)
				ST_IDLE: begin
					if (is_br || skip_now) begin
						state <= ST_SECOND;
					end
				end
				ST_SECOND: begin
					state <= ST_IDLE;
				end
				default: begin
					state <= ST_IDLE;
				end
			endcase
		end
	end

	// fetched word flushed during the second cycle
	assign discard_fetch = (state == ST_SECOND);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			skip_seen <= 1'b0;
		end else if (is_dsk) begin
			skip_seen <= skip_now;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			program_counter_high_latch <= LATCH_RESET;
			view_addr <= '0;
		end else begin
			if (wr_acc && hit_latch) begin
				program_counter_high_latch <= pwdata[LATCH_W-1:0];
			end
			if (wr_acc && hit_file) begin
				view_addr <= pwdata[FADDR_W-1:0];
			end
		end
	end

	// ==========================================================
	// read mux
	logic [31:0] next_prdata;
	always_comb begin
		next_prdata = 32'h0000_0000;
		if (hit_wreg) begin
			next_prdata[DATA_W-1:0] = acc;
		end else if (hit_status) begin
			next_prdata[STAT_Z] = zero_flag;
			next_prdata[STAT_PD] = powerdown_status_n;
			next_prdata[STAT_TO] = timeout_status_n;
			next_prdata[STAT_BUSY] = busy;
			next_prdata[STAT_SKIP] = skip_seen;
		end else if (hit_pc) begin
			next_prdata[PC_W-1:0] = program_counter;
		end else if (hit_latch) begin
			next_prdata[LATCH_W-1:0] = program_counter_high_latch;
		end else if (hit_wdt) begin
			next_prdata[WDT_W-1:0] = watchdog_counter;
			next_prdata[WDT_W +: PRE_W] = watchdog_prescaler;
		end else if (hit_file) begin
			next_prdata[FADDR_W-1:0] = view_addr;
		end else if (hit_fdata) begin
			next_prdata[DATA_W-1:0] = view_data;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (psel && !penable && !pwrite) begin
			prdata <= next_prdata;
		end
	end
endmodule

// [sim/exec_unit_props.sv]
// port assertions for the execution unit
`timescale 1ns/1ps
module exec_unit_props
	import exec_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic pready,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [WDT_W-1:0] watchdog_counter,
	input wire logic [PRE_W-1:0] watchdog_prescaler,
	input wire logic timeout_status_n,
	input wire logic powerdown_status_n,
	input wire logic discard_fetch,
	input wire logic [PC_W-1:0] program_counter
);
	// ==========
	// command decode
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	wire logic cmd = psel && penable && pready && pwrite && paddr == ADDR_CMD;
	wire logic [2:0] op = pwdata[CMD_OP_LO+:CMD_OP_W];
	wire logic jump = cmd && (op == 3'h5 || op == 3'h6);
	sequence s_cmd(int code);
		cmd && op == code;
	endsequence
	sequence s_pulse;
		discard_fetch ##1 !discard_fetch;
	endsequence
	// ==========
	// assertions
	a_wdt_count: assert property (s_cmd(2) |=> watchdog_counter == WDT_ZERO)
		else $error("watchdog counter not cleared");
	a_wdt_prescale: assert property (s_cmd(2) |=> watchdog_prescaler == PRE_ZERO)
		else $error("prescaler not cleared");
	a_wdt_status: assert property (s_cmd(2) |=> timeout_status_n && powerdown_status_n)
		else $error("status bits not set");
	a_branch_two: assert property (s_cmd(6) |=> s_pulse)
		else $error("branch second cycle missing");
	a_discard_cause: assert property ($rose(discard_fetch) |-> $past(jump))
		else $error("discard without skip or branch");
	a_discard_once: assert property (discard_fetch |=> !discard_fetch)
		else $error("discard longer than one cycle");
	a_plain_keep: assert property (cmd && !jump |=> !discard_fetch)
		else $error("discard after plain op");
	a_read_ready: assert property (psel && penable && !pwrite |-> pready)
		else $error("read not answered at once");
	a_branch_low: assert property (s_cmd(6) |=> program_counter[BRANCH_W-1:0] == $past(pwdata[BRANCH_W-1:0]))
		else $error("branch target not loaded");
endmodule
bind exec_unit exec_unit_props u_props (.pclk, .presetn, .psel, .penable, .pwrite, .pready,
	.paddr, .pwdata, .watchdog_counter, .watchdog_prescaler, .timeout_status_n,
	.powerdown_status_n, .discard_fetch, .program_counter);

// [sim/exec_unit_tb.sv]
// self-checking bench for the execution unit
`timescale 1ns/1ps
module exec_unit_tb
	import exec_pkg::*;
;
	// ==========
	// stimulus state
	typedef struct packed {
		logic [2:0] op;
		logic d;
		logic [6:0] f;
		logic [7:0] init;
		logic [7:0] ef;
		logic [7:0] ea;
		logic ez;
	} row_t;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [11:0] paddr = 12'h0;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, q;
	logic pready, pslverr, err, timeout_status_n, powerdown_status_n, discard_fetch;
	logic [PC_W-1:0] program_counter;
	logic [7:0] watchdog_counter, watchdog_prescaler;
	logic [6:0] lat = 7'h5a;
	int num_errors = 0, total_checks = 0, cycles = 0, pulses = 0;
	// accumulator preset to 5a before each row
	row_t rows [8] = '{
		'{OP_CLEAR_FILE, 1'b1, 7'h7f, 8'ha5, 8'h00, 8'h5a, 1'b1},
		'{OP_CLEAR_ACC, 1'b0, 7'h10, 8'h33, 8'h33, 8'h00, 1'b1},
		'{OP_INVERT, 1'b0, 7'h05, 8'h0f, 8'h0f, 8'hf0, 1'b0},
		'{OP_INVERT, 1'b1, 7'h00, 8'hff, 8'h00, 8'h5a, 1'b1},
		'{OP_DECREMENT, 1'b0, 7'h20, 8'h01, 8'h01, 8'h00, 1'b1},
		'{OP_DECREMENT, 1'b1, 7'h21, 8'h00, 8'hff, 8'h5a, 1'b0},
		'{OP_DEC_SKIP, 1'b1, 7'h22, 8'h05, 8'h04, 8'h5a, 1'b0},
		'{OP_DEC_SKIP, 1'b0, 7'h23, 8'h01, 8'h01, 8'h00, 1'b0}
	};
	exec_unit u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .program_counter, .watchdog_counter, .watchdog_prescaler,
		.timeout_status_n, .powerdown_status_n, .discard_fetch);
	always #5 pclk = ~pclk;
	always @(negedge pclk) if (discard_fetch === 1'b1) pulses++;
	always @(posedge pclk) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			num_errors++;
			end_of_test();
		end
	end
	// ==========
	// tasks
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) begin
			@(posedge pclk);
		end
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	function automatic logic [31:0] cw(input logic [2:0] op, input logic d, input logic [10:0] k);
		return {13'h0, op, 4'h0, d, k};
	endfunction
	task automatic end_of_test();
		$display("errors %0d checks %0d", num_errors, total_checks);
		if (num_errors == 0 && total_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// ==========
	// sequence
	initial begin
		repeat (6) @(posedge pclk);
		chk(32'({watchdog_prescaler, watchdog_counter, program_counter}), 32'h0);
		chk(32'({timeout_status_n, powerdown_status_n, discard_fetch}), 32'h6);
		presetn <= 1'b1;
		@(posedge pclk);
		foreach (rows[i]) begin
			apb(1'b1, ADDR_FILE, 32'(rows[i].f));
			apb(1'b1, ADDR_FDATA, 32'(rows[i].init));
			apb(1'b1, ADDR_WREG, 32'h5a);
			apb(1'b1, ADDR_CMD, cw(rows[i].op, rows[i].d, {4'h0, rows[i].f}));
			apb(1'b0, ADDR_FDATA, 32'h0);
			chk(q, rows[i].ef);
			apb(1'b0, ADDR_WREG, 32'h0);
			chk(q, rows[i].ea);
			apb(1'b0, ADDR_STATUS, 32'h0);
			chk(32'(q[STAT_Z]), 32'(rows[i].ez));
		end
		chk(32'(pulses), 32'h1);
		// seven plain commands step once, the taken skip steps twice
		chk(32'(program_counter), 32'h9);
		apb(1'b1, ADDR_WDT, 32'ha55a);
		apb(1'b1, ADDR_STATUS, 32'h0);
		chk(32'({timeout_status_n, powerdown_status_n, watchdog_prescaler, watchdog_counter}),
			32'ha55a);
		apb(1'b1, ADDR_CMD, cw(OP_WDT_CLEAR, 1'b0, 11'h0));
		@(negedge pclk);
		chk(32'({watchdog_prescaler, watchdog_counter}), 32'h0);
		chk(32'({timeout_status_n, powerdown_status_n}), 32'h3);
		@(posedge pclk);
		apb(1'b1, ADDR_LATCH, 32'(lat));
		apb(1'b1, ADDR_CMD, cw(OP_BRANCH, 1'b1, 11'h7ff));
		@(negedge pclk);
		chk(32'(program_counter), 32'({lat[LATCH_HI:LATCH_LO], 11'h7ff}));
		chk(32'(pulses), 32'h2);
		@(posedge pclk);
		apb(1'b1, 12'h020, 32'hff);
		apb(1'b0, 12'h020, 32'h0);
		chk(q, 32'h0);
		chk(32'(err), 32'h1);
		end_of_test();
	end
endmodule
